/* test/general_purpose_port_io_tb_top.sv */
// self-checking bench for the port block with an external pin model
// assumes the checker is bound through its own file
`timescale 1ns/1ns
module general_purpose_port_io_tb_top;
   import gpio_port_pkg::*;
   logic mclk, rst, clkEn, sfrWr, sfrRd, sfrRmw, crossbarOn, sfrHit, pend;
   logic [7:0] sfrAddr, sfrWdata, sfrRdata, v, c;
   logic [2:0] sfrBit;
   access_t sfrKind;
   logic [16:0] xbarClaim, xbarLevel, pinIn, pinOut, pinOe, ext;
   int err_count = 0;
   int comparisons = 0;
   logic [7:0] q[$];
   gpio_port i_gpio_port (.mclk(mclk), .rst(rst), .clkEn(clkEn),
      .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrKind(sfrKind),
      .sfrBit(sfrBit), .sfrRmw(sfrRmw), .sfrWdata(sfrWdata),
      .sfrRdata(sfrRdata), .sfrHit(sfrHit), .crossbarOn(crossbarOn),
      .xbarClaim(xbarClaim), .xbarLevel(xbarLevel), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe));
   pin_partner i_pin_partner (.pinOut(pinOut), .pinOe(pinOe), .ext(ext),
      .pinIn(pinIn));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d,
      e, input logic rm = 1'b0, input access_t k = ACC_BYTE,
      input logic [2:0] b = 3'h0);
      @(negedge mclk);
      {sfrAddr, sfrWr, sfrRd, sfrWdata, sfrRmw, sfrBit} = {a, w, !w, d, rm, b};
      sfrKind = k;
      if (!w) q.push_back(e);
   endtask : acc
   task automatic idle(input int n);
      @(negedge mclk);
      {sfrWr, sfrRd, sfrRmw} = 3'h0;
      repeat (n - 1) @(negedge mclk);
   endtask : idle
   task automatic chk(input logic [7:0] g, e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t read %h expected %h", $time, g, e);
      end
   endtask : chk
   task summarize;
      if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   always @(posedge mclk) pend <= clkEn && sfrRd && !rst;
   always @(negedge mclk) if (pend) chk(sfrRdata, q.pop_front());
   initial begin
      #5000;
      err_count++;
      summarize();
   end
   initial begin
      {rst, clkEn, sfrWr, sfrRd, sfrRmw, crossbarOn} = 6'h31;
      {sfrAddr, sfrWdata, sfrBit, xbarClaim, xbarLevel} = 53'h0;
      sfrKind = ACC_BYTE;
      void'($urandom(32'h0b0724a5));
      {ext, v, c} = {17'($urandom), 8'($urandom), 8'($urandom)};
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      acc(8'hd5, 1'b0, 8'h00, 8'h00);
      acc(8'h80, 1'b0, 8'h00, 8'hff, 1'b1);
      acc(8'h00, 1'b1, 8'h5a, 8'h00);
      acc(8'h00, 1'b0, 8'h00, 8'h00);
      acc(8'hd5, 1'b1, 8'hff, 8'h00);
      acc(8'hd5, 1'b0, 8'h00, 8'h7f);
      acc(8'h80, 1'b0, 8'h00, 8'h00);
      acc(8'ha0, 1'b0, 8'h00, {7'h00, ext[16]});
      acc(8'hf1, 1'b1, 8'h00, 8'h00);
      acc(8'ha4, 1'b1, 8'hff, 8'h00);
      acc(8'h80, 1'b1, v, 8'h00);
      idle(4);
      acc(8'h80, 1'b0, 8'h00, v);
      acc(8'ha4, 1'b1, 8'h00, 8'h00);
      idle(4);
      acc(8'h80, 1'b0, 8'h00, v & ext[7:0]);
      acc(8'h80, 1'b1, {7'h00, ~v[3]}, 8'h00, 1'b0, ACC_BIT, 3'h3);
      acc(8'h80, 1'b0, 8'h00, v ^ 8'h08, 1'b1);
      idle(1);
      clkEn = 1'b0;
      acc(8'h80, 1'b1, ~v, 8'h00);
      idle(1);
      clkEn = 1'b1;
      acc(8'h80, 1'b0, 8'h00, v ^ 8'h08, 1'b1);
      acc(8'ha4, 1'b1, 8'hff, 8'h00);
      {xbarClaim, xbarLevel} = {17'h000ff, 9'h000, c};
      idle(4);
      acc(8'h80, 1'b0, 8'h00, c & ext[7:0]);
      acc(8'hd4, 1'b1, 8'hff, 8'h00);
      acc(8'hd4, 1'b0, 8'h00, 8'hff);
      acc(8'ha0, 1'b1, 8'hfe, 8'h00);
      acc(8'ha0, 1'b0, 8'h00, 8'h00, 1'b1);
      acc(8'hf2, 1'b1, 8'h00, 8'h00);
      acc(8'ha5, 1'b1, 8'h0f, 8'h00);
      acc(8'ha5, 1'b0, 8'h00, 8'h0f);
      acc(8'h90, 1'b1, c, 8'h00);
      idle(4);
      acc(8'h80, 1'b0, 8'h00, v ^ 8'h08);
      acc(8'ha0, 1'b0, 8'h00, 8'h00);
      acc(8'h90, 1'b0, 8'h00, c & {ext[15:12], 4'hf});
      crossbarOn = 1'b0;
      idle(4);
      acc(8'h80, 1'b0, 8'h00, ext[7:0]);
      idle(3);
      summarize();
   end
endmodule : general_purpose_port_io_tb_top

/* test/gpio_port_monitor.sv */
// port block checker, bound to gpio_port
// assumes clkEn is high while reset is held
`timescale 1ns/1ns
module gpio_port_monitor
   import gpio_port_pkg::*;
#(parameter int P0W = 8, parameter int P1W = 8, parameter int P2W = 1) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic clkEn,
   // register access
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic sfrRd,
   input wire access_t sfrKind,
   input wire logic sfrRmw,
   input wire logic [7:0] sfrWdata,
   input wire logic [7:0] sfrRdata,
   input wire logic sfrHit,
   // crossbar and pins
   input wire logic crossbarOn,
   input wire logic [P0W+P1W+P2W-1:0] xbarClaim,
   input wire logic [P0W+P1W+P2W-1:0] pinOut,
   input wire logic [P0W+P1W+P2W-1:0] pinOe
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   wire logic take = clkEn && (sfrRd || sfrWr);
   wire logic wr0 = clkEn && sfrWr && sfrAddr == 8'h80 && sfrKind == ACC_BYTE;
   hit_port0_a: assert property (take && sfrAddr == 8'h80 |=> sfrHit)
      else $error("port0 access gave no hit");
   idle_nohit_a: assert property (clkEn && !take |=> !sfrHit)
      else $error("hit without access");
   unmapped_zero_a: assert property (take && sfrAddr == 8'h00 |=>
      !sfrHit && sfrRdata == 8'h00) else $error("unmapped access answered");
   port2_upper_a: assert property (clkEn && sfrRd && sfrAddr == 8'ha0
      |=> sfrRdata[7:1] == 7'h00) else $error("port2 upper bits not zero");
   latch_to_pin_a: assert property (wr0 ##1 (clkEn &&
      xbarClaim[7:0] == 8'h00) |=> pinOut[7:0] == $past(sfrWdata, 2))
      else $error("pin level differs from written latch");
   xbar_off_a: assert property (clkEn && !crossbarOn |=> pinOe == '0)
      else $error("driver on while crossbar off");
   freeze_a: assert property (!clkEn |=>
      $stable(pinOut) && $stable(sfrRdata)) else $error("state moved frozen");
   reset_quiet_a: assert property (disable iff (1'b0) rst && clkEn |=>
      pinOe == '0 && !sfrHit && sfrRdata == 8'h00) else $error("reset dirty");
   cover property (wr0);
   cover property (clkEn && sfrRd && sfrRmw);
   cover property (clkEn && !crossbarOn);
endmodule : gpio_port_monitor
bind gpio_port gpio_port_monitor #(.P0W(P0W), .P1W(P1W), .P2W(P2W)) i_mon (
   .mclk(mclk), .rst(rst), .clkEn(clkEn), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
   .sfrRd(sfrRd), .sfrKind(sfrKind), .sfrRmw(sfrRmw), .sfrWdata(sfrWdata),
   .sfrRdata(sfrRdata), .sfrHit(sfrHit), .crossbarOn(crossbarOn),
   .xbarClaim(xbarClaim), .pinOut(pinOut), .pinOe(pinOe));

/* test/pin_partner.sv */
// external pins seen by the port block
// assumes pin enables are high while the block drives
`timescale 1ns/1ns
module pin_partner (
   // design side
   input wire logic [16:0] pinOut,
   input wire logic [16:0] pinOe,
   // outside level
   input wire logic [16:0] ext,
   output logic [16:0] pinIn
);
   // released pins show the outside level, never the last driven value
   assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
endmodule : pin_partner

/* verilog/gpio_port.sv */
// special function register front end and three general purpose ports
// assumes core gives address, byte/bit strobes and a read-modify-write flag
//
// Behaviour
// - pins not claimed by crossbar or analog serve as software GPIO
// - each port register accepts byte and single-bit core accesses
// - writes land in an output latch that drives pins until next write
// - plain reads return sampled pin levels, even for crossbar pins
// - read-modify-write reads return the latch, not the pins
// - bit move, clear and set to a port bit read and modify the latch
// - while crossbarOn is set, latch 0 drives low, latch 1 drives high in push-pull and releases the pin in open-drain
`timescale 1ns/1ns
`include "gpio_port_params.svh"
module gpio_port
   import gpio_port_pkg::*;
#(
   parameter int P0W = 8,
   parameter int P1W = 8,
   parameter int P2W = 1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic clkEn,
   // register access
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic sfrRd,
   input wire access_t sfrKind,
   input wire logic [2:0] sfrBit,
   input wire logic sfrRmw,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata,
   output logic sfrHit,
   // crossbar
   input wire logic crossbarOn,
   input wire logic [P0W+P1W+P2W-1:0] xbarClaim,
   input wire logic [P0W+P1W+P2W-1:0] xbarLevel,
   // pins
   input wire logic [P0W+P1W+P2W-1:0] pinIn,
   output logic [P0W+P1W+P2W-1:0] pinOut,
   output logic [P0W+P1W+P2W-1:0] pinOe
);
   localparam int N = P0W + P1W + P2W;
   // decode and read mux assume exactly this port layout
   if (P0W != 8 || P1W != 8 || P2W != 1) begin : g_bad_widths
      $error("port widths fixed by the register map");
   end

   logic [7:0] lat0, lat1, lat2;
   logic [7:0] drv0, drv1, drv2;
   logic [7:0] skip0, skip1;
   logic [7:0] ana0, ana1;
   // sampled pin levels, one vector per port
   wire [P0W-1:0] level0;
   wire [P1W-1:0] level1;
   wire [P2W-1:0] level2;
   // driven level and driver enable, one vector per port
   wire [P0W-1:0] out0;
   wire [P1W-1:0] out1;
   wire [P2W-1:0] out2;
   wire [P0W-1:0] oe0;
   wire [P1W-1:0] oe1;
   wire [P2W-1:0] oe2;

   // decode
   wire hL0 = sfrAddr == `ADDR_PORT0_LATCH;
   wire hL1 = sfrAddr == `ADDR_PORT1_LATCH;
   wire hL2 = sfrAddr == `ADDR_PORT2_LATCH;
   wire hD0 = sfrAddr == `ADDR_PORT0_DRIVE;
   wire hD1 = sfrAddr == `ADDR_PORT1_DRIVE;
   wire hD2 = sfrAddr == `ADDR_PORT2_DRIVE;
   wire hS0 = sfrAddr == `ADDR_PORT0_SKIP;
   wire hS1 = sfrAddr == `ADDR_PORT1_SKIP;
   wire hA0 = sfrAddr == `ADDR_PORT0_ANALOG;
   wire hA1 = sfrAddr == `ADDR_PORT1_ANALOG;
   wire hLatch = hL0 | hL1 | hL2;
   wire hit = hLatch | hD0 | hD1 | hD2 | hS0 | hS1 | hA0 | hA1;
   wire bitOp = sfrKind == ACC_BIT;

   // pin levels per port, gated for analog
   wire [7:0] pin0 = level0;
   wire [7:0] pin1 = level1;
   wire [7:0] pin2 = {7'h00, level2};

   // latch-vs-pin read source
   wire useLatch = sfrRmw | (bitOp & sfrWr);
   wire [7:0] latRd = hL0 ? lat0 : hL1 ? lat1 : lat2 & `PORT2_PIN_MASK;
   wire [7:0] pinRd = hL0 ? pin0 : hL1 ? pin1 : pin2;
   wire [7:0] portRd = useLatch ? latRd : pinRd;
   wire [7:0] cfgRd =
      hD0 ? drv0 : hD1 ? drv1 : hD2 ? (drv2 & `PORT2_PIN_MASK) :
      hS0 ? skip0 : hS1 ? (skip1 & `PORT1_SKIP_MASK) :
      hA0 ? ana0 : hA1 ? ana1 : 8'h00;
   wire [7:0] regVal = hLatch ? portRd : cfgRd;

   // bit writes merge one bit into the addressed latch or config register content
   wire [7:0] bitMask = 8'h01 << sfrBit;
   wire [7:0] oldVal = hLatch ? latRd : cfgRd;
   wire [7:0] bitVal = (oldVal & ~bitMask) | ({8{sfrWdata[0]}} & bitMask);
   wire [7:0] wval = bitOp ? bitVal : sfrWdata;
   wire we = clkEn & sfrWr;

   always_ff @(posedge mclk) begin
      if (rst) begin
         lat0 <= `RST_LATCH;
         lat1 <= `RST_LATCH;
         lat2 <= `RST_PORT2_LATCH;
      end else if (we) begin
         if (hL0) lat0 <= wval;
         if (hL1) lat1 <= wval;
         if (hL2) lat2 <= wval & `PORT2_PIN_MASK;
      end
   end

   // output mode: 1 = push-pull, 0 = open-drain
   always_ff @(posedge mclk) begin
      if (rst) begin
         drv0 <= `RST_DRIVE;
         drv1 <= `RST_DRIVE;
         drv2 <= `RST_DRIVE;
      end else if (we) begin
         if (hD0) drv0 <= wval;
         if (hD1) drv1 <= wval;
         if (hD2) drv2 <= wval & `PORT2_PIN_MASK;
      end
   end

   // skip bits keep a pin away from crossbar peripherals
   always_ff @(posedge mclk) begin
      if (rst) begin
         skip0 <= `RST_SKIP;
         skip1 <= `RST_SKIP;
      end else if (we) begin
         if (hS0) skip0 <= wval;
         if (hS1) skip1 <= wval & `PORT1_SKIP_MASK;
      end
   end

   // analog select: 1 = analog, driver and receiver off
   always_ff @(posedge mclk) begin
      if (rst) begin
         ana0 <= `RST_ANALOG;
         ana1 <= `RST_ANALOG;
      end else if (we) begin
         if (hA0) ana0 <= wval;
         if (hA1) ana1 <= wval;
      end
   end

   // read data registered so outputs come from flops
   always_ff @(posedge mclk) begin
      if (rst) begin
         sfrRdata <= 8'h00;
         sfrHit <= 1'b0;
      end else if (clkEn) begin
         sfrRdata <= (sfrRd & hit) ? regVal : 8'h00;
         sfrHit <= (sfrRd | sfrWr) & hit;
      end
   end

   // skip bits are consumed by the crossbar; here they only deny claims
   wire [N-1:0] skipAll = {1'b0, skip1, skip0};
   wire [N-1:0] claim = xbarClaim & ~skipAll;
   // a skipped pin falls back to its own latch and mode bits
   // port 2 has no analog mode, its pin stays digital
   wire [P2W-1:0] ana2 = '0;

   // one cell per port register, so each keeps its own width check
   // port 0
   port_pin_cell #(.WIDTH(P0W)) cell0 (
      .mclk(mclk),
      .rst(rst),
      .clkEn(clkEn),
      .latch(lat0),
      .pushPull(drv0),
      .analogSel(ana0),
      .crossbarOn(crossbarOn),
      .xbarClaim(claim[P0W-1:0]),
      .xbarLevel(xbarLevel[P0W-1:0]),
      .pinIn(pinIn[P0W-1:0]),
      .pinOut(out0),
      .pinOe(oe0),
      .pinLevel(level0)
   );

   // port 1
   port_pin_cell #(.WIDTH(P1W)) cell1 (
      .mclk(mclk),
      .rst(rst),
      .clkEn(clkEn),
      .latch(lat1),
      .pushPull(drv1),
      .analogSel(ana1),
      .crossbarOn(crossbarOn),
      .xbarClaim(claim[P0W+P1W-1:P0W]),
      .xbarLevel(xbarLevel[P0W+P1W-1:P0W]),
      .pinIn(pinIn[P0W+P1W-1:P0W]),
      .pinOut(out1),
      .pinOe(oe1),
      .pinLevel(level1)
   );

   // port 2 is a single pin
   port_pin_cell #(.WIDTH(P2W)) cell2 (
      .mclk(mclk),
      .rst(rst),
      .clkEn(clkEn),
      .latch(lat2[P2W-1:0]),
      .pushPull(drv2[P2W-1:0]),
      .analogSel(ana2),
      .crossbarOn(crossbarOn),
      .xbarClaim(claim[N-1:P0W+P1W]),
      .xbarLevel(xbarLevel[N-1:P0W+P1W]),
      .pinIn(pinIn[N-1:P0W+P1W]),
      .pinOut(out2),
      .pinOe(oe2),
      .pinLevel(level2)
   );

   // outputs stay the cells' flops, only regrouped here
   assign pinOut = {out2, out1, out0};
   assign pinOe = {oe2, oe1, oe0};
endmodule : gpio_port

/* verilog/gpio_port_params.svh */
// register offsets and reset values for the general purpose port block
// assumes byte-wide special function register space with 8-bit addresses
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH
`define ADDR_PORT0_LATCH 8'h80
`define ADDR_PORT1_LATCH 8'h90
`define ADDR_PORT2_LATCH 8'ha0
`define ADDR_PORT0_DRIVE 8'ha4
`define ADDR_PORT1_DRIVE 8'ha5
`define ADDR_PORT2_DRIVE 8'ha6
`define ADDR_PORT0_SKIP 8'hd4
`define ADDR_PORT1_SKIP 8'hd5
`define ADDR_PORT0_ANALOG 8'hf1
`define ADDR_PORT1_ANALOG 8'hf2
`define RST_LATCH 8'hff
`define RST_PORT2_LATCH 8'h01
`define RST_DRIVE 8'h00
`define RST_SKIP 8'h00
`define RST_ANALOG 8'hff
`define PORT1_SKIP_MASK 8'h7f
`define PORT2_PIN_MASK 8'h01
`endif

/* verilog/gpio_port_pkg.sv */
// types shared by the general purpose port block
// assumes gpio_port_params.svh is compiled alongside
package gpio_port_pkg;
   typedef enum logic [1:0] {
      ACC_BYTE = 2'b01,
      ACC_BIT = 2'b10
   } access_t;
endpackage : gpio_port_pkg

/* verilog/port_pin_cell.sv */
// one port of up to eight pins: output drive and input gating
// assumes the crossbar supplies per-pin claim and level
`timescale 1ns/1ns
module port_pin_cell #(
   parameter int WIDTH = 8
) (
   // clock
   input wire logic mclk,
   input wire logic rst,
   input wire logic clkEn,
   // configuration
   input wire logic [WIDTH-1:0] latch,
   input wire logic [WIDTH-1:0] pushPull,
   input wire logic [WIDTH-1:0] analogSel,
   input wire logic crossbarOn,
   input wire logic [WIDTH-1:0] xbarClaim,
   input wire logic [WIDTH-1:0] xbarLevel,
   // pins
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut,
   output logic [WIDTH-1:0] pinOe,
   output logic [WIDTH-1:0] pinLevel
);
   // one cell serves one port register, never more than eight pins
   if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
      $error("port width must be 1..8");
   end
   wire [WIDTH-1:0] level = (xbarClaim & xbarLevel) | (~xbarClaim & latch);
   // crossbar-owned pins are open-drain regardless of mode bits
   wire [WIDTH-1:0] pp = pushPull & ~xbarClaim;
   wire [WIDTH-1:0] driveEn =
      {WIDTH{crossbarOn}} & ~analogSel & (pp | ~level);
   wire [WIDTH-1:0] sampled = pinIn & ~analogSel;
   always_ff @(posedge mclk) begin
      if (rst) begin
         pinOut <= '0;
         pinOe <= '0;
         pinLevel <= '0;
      end else if (clkEn) begin
         pinOut <= level;
         pinOe <= driveEn;
         pinLevel <= sampled;
      end
   end
endmodule : port_pin_cell
